// file: omd_host_model.sv
// Host controller model driving the two-wire bus
`timescale 1ns/1ps
module omd_host_model (
  // Clock
  input wire logic clk,
  // Two-wire bus
  input wire logic sdaLine,
  output logic scl,
  output logic sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic hw();
    repeat (10) @(negedge clk);
  endtask : hw
  // ====
  // Start or repeated start, and stop
  task automatic start();
    sdaLow = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    sdaLow = 1'b1;
    hw();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sdaLow = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    sdaLow = 1'b0;
    hw();
  endtask : stop
  // ====
  // Bits and bytes, line sampled with clock high
  task automatic bit_io(input logic b, output logic s);
    sdaLow = !b;
    hw();
    scl = 1'b1;
    hw();
    s = sdaLine;
    scl = 1'b0;
  endtask : bit_io
  task automatic byte_io(input logic [7:0] w, input logic a, output logic [7:0] r,
                         output logic k);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(a, k);
  endtask : byte_io
endmodule : omd_host_model

// file: omd_mem.sv
// Two 256-byte pages of management memory with registered read data
`timescale 1ns/1ps
module omd_mem
  import omd_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Memory port
  omd_mem_if.store mem
);

  // ==========================================================
  // Storage
  logic [7:0] store [0:511];

  always_ff @(posedge clk) begin
    if (ce && mem.we) begin
      store[mem.addr] <= mem.wdata;
    end
  end

  // ==========================================================
  // Registered read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem.rdata <= 8'h00;
    end else if (ce) begin
      mem.rdata <= store[mem.addr];
    end
  end

endmodule : omd_mem

// file: omd_mem_if.sv
// Carrier between the control logic and its memory
`timescale 1ns/1ps
interface omd_mem_if;
  logic we;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport ctrl (output we, output addr, output wdata, input rdata);
  modport store (input we, input addr, input wdata, output rdata);
endinterface : omd_mem_if

// file: omd_pkg.sv
// Types shared by the control block and its memory
package omd_pkg;

  // ==========================================================
  // Two-wire slave states
  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_OFFS      = 9'h008,
    ST_OFFS_ACK  = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RACK      = 9'h100
  } omd_state_type;

  // ==========================================================
  // Memory page selected by the device address
  typedef enum logic {
    PAGE_ID   = 1'b0,
    PAGE_DIAG = 1'b1
  } omd_page_type;

endpackage : omd_pkg

// file: omd_regs.svh
// Offsets, field positions, addresses and reset values of the control block
`ifndef OMD_REGS_SVH
`define OMD_REGS_SVH

// ==========================================================
// Two-wire device addresses (8-bit form, write direction)
`define OMD_ID_DEV_ADDR 8'ha0
`define OMD_DIAG_DEV_ADDR 8'ha2

// ==========================================================
// Transmitter control and status byte
`define OMD_TX_CTRL_OFFSET 8'h6e
`define OMD_BIT_TXOFF_STATE 7
`define OMD_BIT_TXOFF_SOFT 6
`define OMD_BIT_LASER_FAULT 2
`define OMD_BIT_SIGNAL_LOST 1
`define OMD_TXOFF_SOFT_RESET 1'b0

// ==========================================================
// Synchroniser reset levels
`define OMD_TXOFF_PIN_RESET 1'b1
`define OMD_LINE_IDLE_RESET 1'b1

// ==========================================================
// Host spacing between transmitter-off assertions
`define OMD_TXOFF_SPACING_MS 10

`endif

// file: omd_tx_diag.sv
// Transmitter control, laser fault latch and two-wire management slave
`timescale 1ns/1ps
`include "omd_regs.svh"

// Operation
// - Management memory is reached over a byte-addressed two-wire EEPROM style bus.
// - Device address a0 answers with a 256-byte identification page.
// - Device address a2 answers with a separate 256-byte diagnostics page.
// - Transmitter-off pin high turns light off; low allows transmission.
// - An undriven transmitter-off pin counts as high, keeping the laser off.
// - Byte 110 holds software off at bit 6, off state at bit 7.
// - Effective transmitter-off is the OR of software bit and pin.
// - A catastrophic laser fault raises the fault output and shuts the laser.
// - Fault output is low in normal operation, high while faulted.
// - Fault stays latched until transmitter-off toggles or power cycles.
// - Laser fault shows at bit 2 of byte 110.
// - Unsafe transmitted power turns the transmitter off.
// - Transmitter-off and signal-lost states are mirrored into diagnostics memory.
// - Signal lost reads at bit 1 of byte 110, high meaning unusable.
module omd_tx_diag
  import omd_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Two-wire bus
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Control pins
  input wire logic txOffPin,
  output logic faultOut,
  output logic faultOe,
  // Laser and receiver monitors
  input wire logic laserFaultDetect,
  input wire logic powerUnsafe,
  input wire logic receive_signal_lost,
  // Laser drive
  output logic txLaserEnable
);

  // ==========================================================
  // Synchronisers
  logic sclMeta, sclSync, sclPrev;
  logic sdaMeta, sdaSync, sdaPrev;
  logic pinMeta, pinSync, pinPrev;
  logic faultMeta, faultSync;
  logic unsafeMeta, unsafeSync;
  logic lostMeta, lostSync;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclMeta <= `OMD_LINE_IDLE_RESET;
      sclSync <= `OMD_LINE_IDLE_RESET;
      sclPrev <= `OMD_LINE_IDLE_RESET;
      sdaMeta <= `OMD_LINE_IDLE_RESET;
      sdaSync <= `OMD_LINE_IDLE_RESET;
      sdaPrev <= `OMD_LINE_IDLE_RESET;
    end else if (ce) begin
      sclMeta <= scl;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinMeta <= `OMD_TXOFF_PIN_RESET;
      pinSync <= `OMD_TXOFF_PIN_RESET;
      pinPrev <= `OMD_TXOFF_PIN_RESET;
      faultMeta <= 1'b0;
      faultSync <= 1'b0;
      unsafeMeta <= 1'b0;
      unsafeSync <= 1'b0;
      lostMeta <= 1'b0;
      lostSync <= 1'b0;
    end else if (ce) begin
      pinMeta <= txOffPin;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
      faultMeta <= laserFaultDetect;
      faultSync <= faultMeta;
      unsafeMeta <= powerUnsafe;
      unsafeSync <= unsafeMeta;
      lostMeta <= receive_signal_lost;
      lostSync <= lostMeta;
    end
  end

  // ==========================================================
  // Bus events
  logic sclRise, sclFall, busStart, busStop;

  assign sclRise = sclSync && !sclPrev;
  assign sclFall = !sclSync && sclPrev;
  assign busStart = sclSync && sclPrev && sdaPrev && !sdaSync;
  assign busStop = sclSync && sclPrev && !sdaPrev && sdaSync;

  // ==========================================================
  // Transmitter control and fault latch
  logic swTxOff;
  logic laserFault;
  logic next_laserFault;
  logic txOffEff;
  logic pinAsserted;

  assign txOffEff = pinSync | swTxOff;
  assign pinAsserted = pinSync && !pinPrev;

  always_comb begin
    next_laserFault = laserFault;
    if (pinAsserted) begin
      next_laserFault = 1'b0;
    end
    if (faultSync || unsafeSync) begin
      next_laserFault = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      laserFault <= 1'b0;
      faultOut <= 1'b0;
      faultOe <= 1'b1;
    end else if (ce) begin
      laserFault <= next_laserFault;
      faultOut <= 1'b0;
      faultOe <= !next_laserFault;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txLaserEnable <= 1'b0;
    end else if (ce) begin
      txLaserEnable <= !(txOffEff | next_laserFault);
    end
  end

  // ==========================================================
  // Memory port
  omd_mem_if mem ();

  omd_page_type page;
  logic [7:0] ptr;
  logic memWe;
  logic [7:0] memWdata;
  logic [7:0] ctrlByte;
  logic [7:0] readByte;
  logic ctrlHit;

  assign mem.we = memWe;
  assign mem.addr = {page, ptr};
  assign mem.wdata = memWdata;

  assign ctrlHit = (page == PAGE_DIAG) && (ptr == `OMD_TX_CTRL_OFFSET);

  always_comb begin
    ctrlByte = 8'h00;
    ctrlByte[`OMD_BIT_TXOFF_STATE] = txOffEff;
    ctrlByte[`OMD_BIT_TXOFF_SOFT] = swTxOff;
    ctrlByte[`OMD_BIT_LASER_FAULT] = laserFault;
    ctrlByte[`OMD_BIT_SIGNAL_LOST] = lostSync;
  end

  assign readByte = ctrlHit ? ctrlByte : mem.rdata;

  omd_mem u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .mem(mem.store)
  );

  // ==========================================================
  // Two-wire slave
  omd_state_type state;
  logic [2:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] txShift;
  logic [7:0] rxByte;
  logic gotByte;
  logic readDir;
  logic masterAck;

  assign rxByte = {shiftIn[6:0], sdaSync};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      bitCnt <= 3'h0;
      shiftIn <= 8'h00;
      txShift <= 8'h00;
      gotByte <= 1'b0;
      readDir <= 1'b0;
      masterAck <= 1'b0;
      page <= PAGE_ID;
      ptr <= 8'h00;
      memWe <= 1'b0;
      memWdata <= 8'h00;
      swTxOff <= `OMD_TXOFF_SOFT_RESET;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
    end else if (ce) begin
      memWe <= 1'b0;
      sdaOut <= 1'b0;
      if (busStart) begin
        state <= ST_ADDR;
        bitCnt <= 3'h0;
        gotByte <= 1'b0;
        sdaOe <= 1'b0;
      end else if (busStop) begin
        state <= ST_IDLE;
        sdaOe <= 1'b0;
      end else if (sclRise) begin
        case (state)
          ST_ADDR, ST_OFFS, ST_WDATA: begin
            shiftIn <= rxByte;
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7) begin
              gotByte <= 1'b1;
              if (state == ST_ADDR) begin
                if (rxByte[7:1] == 7'(`OMD_ID_DEV_ADDR >> 1)) begin
                  page <= PAGE_ID;
                  readDir <= rxByte[0];
                end else if (rxByte[7:1] == 7'(`OMD_DIAG_DEV_ADDR >> 1)) begin
                  page <= PAGE_DIAG;
                  readDir <= rxByte[0];
                end else begin
                  state <= ST_IDLE;
                  gotByte <= 1'b0;
                end
              end else if (state == ST_OFFS) begin
                ptr <= rxByte;
              end else begin
                if (ctrlHit) begin
                  swTxOff <= rxByte[`OMD_BIT_TXOFF_SOFT];
                end else begin
                  memWe <= 1'b1;
                  memWdata <= rxByte;
                end
              end
            end
          end
          ST_RACK: begin
            masterAck <= !sdaSync;
          end
          default: begin
          end
        endcase
      end else if (sclFall) begin
        case (state)
          ST_ADDR: begin
            if (gotByte) begin
              gotByte <= 1'b0;
              sdaOe <= 1'b1;
              state <= ST_ADDR_ACK;
            end
          end
          ST_OFFS: begin
            if (gotByte) begin
              gotByte <= 1'b0;
              sdaOe <= 1'b1;
              state <= ST_OFFS_ACK;
            end
          end
          ST_WDATA: begin
            if (gotByte) begin
              gotByte <= 1'b0;
              sdaOe <= 1'b1;
              ptr <= ptr + 8'h1;
              state <= ST_WDATA_ACK;
            end
          end
          ST_ADDR_ACK: begin
            bitCnt <= 3'h0;
            if (readDir) begin
              txShift <= readByte;
              sdaOe <= !readByte[7];
              state <= ST_RDATA;
            end else begin
              sdaOe <= 1'b0;
              state <= ST_OFFS;
            end
          end
          ST_OFFS_ACK, ST_WDATA_ACK: begin
            sdaOe <= 1'b0;
            bitCnt <= 3'h0;
            state <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bitCnt == 3'h7) begin
              sdaOe <= 1'b0;
              bitCnt <= 3'h0;
              ptr <= ptr + 8'h1;
              state <= ST_RACK;
            end else begin
              bitCnt <= bitCnt + 3'h1;
              txShift <= {txShift[6:0], 1'b0};
              sdaOe <= !txShift[6];
            end
          end
          ST_RACK: begin
            if (masterAck) begin
              txShift <= readByte;
              sdaOe <= !readByte[7];
              state <= ST_RDATA;
            end else begin
              state <= ST_IDLE;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule : omd_tx_diag

// file: omd_tx_diag_asserts.sv
// Concurrent checks on the ports of the transmitter control block
`timescale 1ns/1ps
module omd_tx_diag_asserts (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Two-wire bus
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Control pins
  input wire logic txOffPin,
  input wire logic faultOut,
  input wire logic faultOe,
  // Monitors and laser drive
  input wire logic laserFaultDetect,
  input wire logic powerUnsafe,
  input wire logic receive_signal_lost,
  input wire logic txLaserEnable
);
  // ====
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_pin_off: assert property (txOffPin [*4] |-> !txLaserEnable)
    else $error("Laser on with off pin high");
  chk_fault_laser: assert property (laserFaultDetect [*5] |-> !txLaserEnable)
    else $error("Laser on during laser fault");
  chk_unsafe_off: assert property (powerUnsafe [*5] |-> !txLaserEnable)
    else $error("Laser on with unsafe power");
  chk_fault_flag: assert property ((laserFaultDetect || powerUnsafe) [*5] |-> !faultOe)
    else $error("Fault line not released on fault");
  chk_fault_hold: assert property (!txOffPin [*4] ##0 !faultOe |=> !faultOe)
    else $error("Fault cleared without off pin toggle");
  chk_fault_clear: assert property (
    (!txOffPin && !laserFaultDetect && !powerUnsafe) [*3] ##1
    (txOffPin && !laserFaultDetect && !powerUnsafe) [*5] |-> faultOe)
    else $error("Fault not cleared by off pin toggle");
  chk_reset_state: assert property ($fell(sys_rst) |-> faultOe && !txLaserEnable && !sdaOe)
    else $error("Wrong state after reset");
  chk_sda_timing: assert property ($changed(sdaOe) |-> !scl && !$past(scl, 2))
    else $error("Data line changed outside clock low");
  chk_sda_open_drain: assert property (!sdaOut)
    else $error("Data line driven high");
  chk_fault_open_drain: assert property (!faultOut)
    else $error("Fault line driven high");
endmodule : omd_tx_diag_asserts

bind omd_tx_diag omd_tx_diag_asserts omd_tx_diag_asserts_i (.clk(clk), .sys_rst(sys_rst),
  .ce(ce), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .txOffPin(txOffPin),
  .faultOut(faultOut), .faultOe(faultOe), .laserFaultDetect(laserFaultDetect),
  .powerUnsafe(powerUnsafe), .receive_signal_lost(receive_signal_lost),
  .txLaserEnable(txLaserEnable));

// file: tb.sv
// Self-checking bench for the transmitter control block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic txOffPin = 1'b1;
  logic laserFault = 1'b0;
  logic unsafe = 1'b0;
  logic sigLost = 1'b0;
  logic scl;
  logic sdaLow;
  logic sdaOe;
  logic faultOe;
  logic laserOn;
  logic [7:0] rv;
  logic k;
  int miscompares = 0;
  int comparisons = 0;
  wire sda = !(sdaOe | sdaLow);
  always #12.5 clk = ~clk;
  omd_tx_diag omd_tx_diag_i (.clk(clk), .sys_rst(sysRst), .ce(1'b1), .scl(scl), .sdaIn(sda),
    .sdaOut(), .sdaOe(sdaOe), .txOffPin(txOffPin), .faultOut(), .faultOe(faultOe),
    .laserFaultDetect(laserFault), .powerUnsafe(unsafe), .receive_signal_lost(sigLost),
    .txLaserEnable(laserOn));
  omd_host_model omd_host_model_i (.clk(clk), .sdaLine(sda), .scl(scl), .sdaLow(sdaLow));
  // ====
  // Tasks
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] d, input logic [7:0] o, input logic [7:0] v);
    logic [7:0] r;
    logic a0, a1, a2;
    omd_host_model_i.start();
    omd_host_model_i.byte_io(d, 1'b1, r, a0);
    omd_host_model_i.byte_io(o, 1'b1, r, a1);
    omd_host_model_i.byte_io(v, 1'b1, r, a2);
    omd_host_model_i.stop();
    chk("write ack", {5'h00, a0, a1, a2}, 8'h00);
  endtask : wr
  task automatic rd(input logic [7:0] d, input logic [7:0] o, output logic [7:0] v);
    logic [7:0] r;
    logic a0, a1, a2, a3;
    omd_host_model_i.start();
    omd_host_model_i.byte_io(d, 1'b1, r, a0);
    omd_host_model_i.byte_io(o, 1'b1, r, a1);
    omd_host_model_i.start();
    omd_host_model_i.byte_io(d | 8'h01, 1'b1, r, a2);
    omd_host_model_i.byte_io(8'hff, 1'b1, v, a3);
    omd_host_model_i.stop();
    chk("read ack", {5'h00, a0, a1, a2}, 8'h00);
  endtask : rd
  // ====
  // Tests
  initial begin
    repeat (3) @(negedge clk);
    sysRst = 1'b0;
    repeat (5) @(negedge clk);
    chk("laser", {7'h00, laserOn}, 8'h00);
    chk("fault line", {7'h00, faultOe}, 8'h01);
    txOffPin = 1'b0;
    repeat (5) @(negedge clk);
    chk("laser", {7'h00, laserOn}, 8'h01);
    wr(8'ha0, 8'h05, 8'h5a);
    wr(8'ha2, 8'h05, 8'ha5);
    rd(8'ha0, 8'h05, rv);
    chk("id page", rv, 8'h5a);
    rd(8'ha2, 8'h05, rv);
    chk("diag page", rv, 8'ha5);
    omd_host_model_i.start();
    omd_host_model_i.byte_io(8'ha4, 1'b1, rv, k);
    omd_host_model_i.stop();
    chk("bad address ack", {7'h00, k}, 8'h01);
    sigLost = 1'b1;
    wr(8'ha2, 8'h6e, 8'hff);
    chk("laser", {7'h00, laserOn}, 8'h00);
    rd(8'ha2, 8'h6e, rv);
    chk("status byte", rv, 8'hc2);
    sigLost = 1'b0;
    wr(8'ha2, 8'h6e, 8'h00);
    chk("laser", {7'h00, laserOn}, 8'h01);
    txOffPin = 1'b1; // Pin spacing scaled down to keep the run short
    rd(8'ha2, 8'h6e, rv);
    chk("status byte", rv, 8'h80);
    txOffPin = 1'b0;
    for (int i = 0; i < 2; i++) begin
      repeat (6) @(negedge clk);
      laserFault = (i == 0);
      unsafe = (i == 1);
      repeat (6) @(negedge clk);
      laserFault = 1'b0;
      unsafe = 1'b0;
      repeat (6) @(negedge clk);
      chk("fault line", {7'h00, faultOe}, 8'h00);
      chk("laser", {7'h00, laserOn}, 8'h00);
      rd(8'ha2, 8'h6e, rv);
      chk("status byte", rv, 8'h04);
      txOffPin = 1'b1; // Pin spacing scaled down to keep the run short
      repeat (6) @(negedge clk);
      txOffPin = 1'b0;
      repeat (6) @(negedge clk);
      chk("fault line", {7'h00, faultOe}, 8'h01);
      chk("laser", {7'h00, laserOn}, 8'h01);
    end
    report_and_stop();
  end
  initial begin
    #1500000;
    miscompares++;
    report_and_stop();
  end
endmodule : tb
